//--- design/ppst_timing.v
// passive panel line, frame and shift clock timing generator
`timescale 1ns/1ps
`default_nettype none

`include "ppst_regs.vh"

// Operation
// RQ1: pixel period is source clock period times divider value plus one.
// RQ2: shift clock period is pixel period times the panel data bus width; widths of one or less give one pulse per line.
// RQ3: frame sync, line sync and shift clock each have selectable polarity.
// RQ4: frame sync lags line sync wait+2, width+1, end wait+1 pixels.
// RQ5: software keeps shift clock at most one fifth of system clock.
// RQ6: software keeps display source clock under its maximum frequency.
// RQ7: first shift clock comes within one shift period after frame sync.
module ppst_timing #(
  parameter DIV_W  = 8,
  parameter WAIT_W = 8,
  parameter BW_W   = 4,
  parameter MAX_BW = 8,
  parameter SCNT_W = 10,
  parameter LINE_W = 10
) (
  input  wire              clk_sys_in,
  input  wire              rst_in,
  input  wire              enable_in,
  input  wire              display_source_clock_in,
  input  wire [DIV_W-1:0]  pixel_clock_divider_in,
  input  wire [BW_W-1:0]   panel_bus_width_in,
  input  wire [WAIT_W-1:0] line_start_wait_in,
  input  wire [WAIT_W-1:0] line_sync_width_in,
  input  wire [WAIT_W-1:0] line_end_wait_in,
  input  wire [SCNT_W-1:0] shifts_per_line_in,
  input  wire [LINE_W-1:0] lines_per_frame_in,
  input  wire              frame_sync_low_in,
  input  wire              line_sync_low_in,
  input  wire              shift_clock_low_in,
  input  wire [MAX_BW-1:0] pixel_word_in,
  output wire              word_req_out,
  output reg  [MAX_BW-1:0] panel_data_lines_out,
  output reg               frame_sync_out,
  output reg               line_sync_out,
  output reg               shift_clock_out,
  output reg               busy_out
);

  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_START = 4'h2;
  localparam [3:0] ST_SHIFT = 4'h4;
  localparam [3:0] ST_END   = 4'h8;

  // zero-extend a field to the phase counter width
  function [WAIT_W:0] ppst_ext;
    input [WAIT_W-1:0] v;
    begin
      ppst_ext = {1'b0, v};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // source clock synchroniser and tick
  reg src_s1;
  reg src_s2;
  reg src_s3;
  wire src_tick = src_s2 & ~src_s3;

  // s1 feeds only s2; the edge detector looks at s2 and s3
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      src_s1 <= 1'b0;
      src_s2 <= 1'b0;
      src_s3 <= 1'b0;
    end else begin
      src_s1 <= display_source_clock_in;
      src_s2 <= src_s1;
      src_s3 <= src_s2;
    end
  end

  wire pix_en;

  ppst_pix_div #(
    .DIV_W (DIV_W)
  ) u_div (
    .clk_sys_in  (clk_sys_in),
    .rst_in      (rst_in),
    .run_in      (enable_in),
    .src_tick_in (src_tick),
    .div_in      (pixel_clock_divider_in),
    .pix_en_out  (pix_en)
  );

  //////////////////////////////////////////////////////////////////////////
  // line sequencer
  reg [3:0]        state;
  reg [WAIT_W:0]   pcnt;      // pixel count inside the current phase
  reg [WAIT_W:0]   wcnt;      // pixel count of the line sync pulse
  reg [SCNT_W-1:0] scnt;
  reg [LINE_W-1:0] line;
  reg              lsync;
  reg              fsync;
  reg              sclk;

  // widths below one behave as one; a width of one gives a single clock pulse per line, not one per shift
  wire [WAIT_W:0] bw_last =
    (panel_bus_width_in == {BW_W{1'b0}}) ? {(WAIT_W+1){1'b0}} :
    {{(WAIT_W+1-BW_W){1'b0}}, panel_bus_width_in - {{(BW_W-1){1'b0}}, 1'b1}};
  wire [WAIT_W:0] bw_half =
    {{(WAIT_W+1-BW_W){1'b0}}, panel_bus_width_in >> 1};

  wire start_done = (state == ST_START) &&
                    (pcnt == ppst_ext(line_start_wait_in) +
                     (`PPST_START_ADD - 1));
  wire period_done = (state == ST_SHIFT) && (pcnt == bw_last);
  wire line_done = period_done &&
                   (scnt == shifts_per_line_in - {{(SCNT_W-1){1'b0}}, 1'b1});
  wire end_done = (state == ST_END) &&
                  (pcnt == ppst_ext(line_end_wait_in) + (`PPST_END_ADD - 1));
  wire new_line = pix_en && (state == ST_IDLE || end_done);
  wire load_now = pix_en && (start_done || (period_done && !line_done));

  // source presents its word in the same cycle as the request; gated so a
  // pixel pulse left over when enable drops never asks for an untaken word
  assign word_req_out = load_now && enable_in && !rst_in;

  // sequencer: start wait, shift periods, end wait [RQ4]
  always @(posedge clk_sys_in) begin
    if (rst_in || !enable_in) begin
      state <= ST_IDLE;
      pcnt  <= {(WAIT_W+1){1'b0}};
      scnt  <= {SCNT_W{1'b0}};
      line  <= {LINE_W{1'b0}};
      fsync <= `PPST_RST_INACTIVE;
      sclk  <= `PPST_RST_INACTIVE;
      panel_data_lines_out <= `PPST_RST_DATA;
    end else if (pix_en) begin
      if (load_now) begin
        panel_data_lines_out <= pixel_word_in;
      end
      case (state)
        ST_IDLE: begin
          state <= ST_START;
          pcnt  <= {(WAIT_W+1){1'b0}};
          line  <= {LINE_W{1'b0}};
        end
        ST_START: begin
          if (start_done) begin // [RQ4]
            state <= ST_SHIFT;
            pcnt  <= {(WAIT_W+1){1'b0}};
            scnt  <= {SCNT_W{1'b0}};
            fsync <= (line == {LINE_W{1'b0}}); // [RQ4]
            sclk  <= (bw_half == {(WAIT_W+1){1'b0}}); // [RQ7]
          end else begin
            pcnt <= pcnt + 1'b1;
          end
        end
        ST_SHIFT: begin
          if (line_done) begin
            state <= ST_END;
            pcnt  <= {(WAIT_W+1){1'b0}};
            sclk  <= 1'b0;
          end else if (period_done) begin // [RQ2]
            pcnt <= {(WAIT_W+1){1'b0}};
            scnt <= scnt + {{(SCNT_W-1){1'b0}}, 1'b1};
            sclk <= (bw_half == {(WAIT_W+1){1'b0}});
          end else begin
            pcnt <= pcnt + 1'b1;
            sclk <= (pcnt + 1'b1 >= bw_half); // [RQ2]
          end
        end
        ST_END: begin
          if (end_done) begin // [RQ4]
            state <= ST_START;
            pcnt  <= {(WAIT_W+1){1'b0}};
            fsync <= 1'b0;
            line  <= (line >= lines_per_frame_in -
                      {{(LINE_W-1){1'b0}}, 1'b1}) ? {LINE_W{1'b0}} :
                     line + {{(LINE_W-1){1'b0}}, 1'b1};
          end else begin
            pcnt <= pcnt + 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // line sync pulse of width plus one pixels; a new line start wins
  always @(posedge clk_sys_in) begin
    if (rst_in || !enable_in) begin
      lsync <= `PPST_RST_INACTIVE;
      wcnt  <= {(WAIT_W+1){1'b0}};
    end else if (pix_en) begin
      if (new_line) begin
        lsync <= 1'b1;
        wcnt  <= {(WAIT_W+1){1'b0}};
      end else if (lsync) begin
        if (wcnt == ppst_ext(line_sync_width_in) +
            (`PPST_WIDTH_ADD - 1)) begin // [RQ4]
          lsync <= 1'b0;
        end else begin
          wcnt <= wcnt + 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // output polarity, registered so pins change on one edge
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      frame_sync_out  <= `PPST_RST_INACTIVE;
      line_sync_out   <= `PPST_RST_INACTIVE;
      shift_clock_out <= `PPST_RST_INACTIVE;
      busy_out        <= 1'b0;
    end else begin
      frame_sync_out  <= fsync ^ frame_sync_low_in; // [RQ3]
      line_sync_out   <= lsync ^ line_sync_low_in;  // [RQ3]
      shift_clock_out <= sclk ^ shift_clock_low_in; // [RQ3]
      busy_out        <= (state != ST_IDLE);
    end
  end

endmodule // ppst_timing

`default_nettype wire

//--- inc/ppst_regs.vh
// constants for the passive panel sync timing generator
`ifndef PPST_REGS_VH
`define PPST_REGS_VH

// pixel period adds one source period to the divider value
`define PPST_DIV_ADD        1
// line sync to frame sync delay adds two pixel periods to the wait field
`define PPST_START_ADD      2
// line sync width adds one pixel period to the width field
`define PPST_WIDTH_ADD      1
// last shift clock to line sync adds one pixel period to the wait field
`define PPST_END_ADD        1
// reset value of the sync and data outputs before polarity is applied
`define PPST_RST_INACTIVE   1'b0
`define PPST_RST_DATA       8'h00

`endif

//--- design/ppst_pix_div.v
// pixel period enable divider fed by display source clock ticks
`timescale 1ns/1ps
`default_nettype none

`include "ppst_regs.vh"

module ppst_pix_div #(
  parameter DIV_W = 8
) (
  input  wire             clk_sys_in,
  input  wire             rst_in,
  input  wire             run_in,
  input  wire             src_tick_in,
  input  wire [DIV_W-1:0] div_in,
  output reg              pix_en_out
);

  reg [DIV_W-1:0] tick_cnt;

  // one pulse every div_in plus one source ticks [RQ1]
  always @(posedge clk_sys_in) begin
    if (rst_in || !run_in) begin
      tick_cnt   <= {DIV_W{1'b0}};
      pix_en_out <= 1'b0;
    end else if (src_tick_in) begin
      if (tick_cnt == div_in) begin // [RQ1]
        tick_cnt   <= {DIV_W{1'b0}};
        pix_en_out <= 1'b1;
      end else begin
        tick_cnt   <= tick_cnt + {{(DIV_W-1){1'b0}}, 1'b1};
        pix_en_out <= 1'b0;
      end
    end else begin
      pix_en_out <= 1'b0;
    end
  end

endmodule // ppst_pix_div

`default_nettype wire

//--- tb/ppst_chk_checker.sv
// port assertions for the passive panel timing generator
`timescale 1ns/1ps
`default_nettype none
module ppst_chk #(parameter MAX_BW = 8) (
  input wire logic              clk_sys_in,
  input wire logic              rst_in,
  input wire logic              enable_in,
  input wire logic              frame_sync_low_in,
  input wire logic              line_sync_low_in,
  input wire logic              shift_clock_low_in,
  input wire logic [MAX_BW-1:0] pixel_word_in,
  input wire logic              word_req_out,
  input wire logic [MAX_BW-1:0] panel_data_lines_out,
  input wire logic              frame_sync_out,
  input wire logic              line_sync_out,
  input wire logic              shift_clock_out,
  input wire logic              busy_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // polarity held while idle, so registered outputs have settled
  sequence quiet_s;
    (!enable_in && $stable({frame_sync_low_in, line_sync_low_in,
      shift_clock_low_in}))[*4];
  endsequence
  sync_idle_a: assert property (quiet_s |->
    frame_sync_out == frame_sync_low_in && line_sync_out == line_sync_low_in)
    else $error("sync idle level wrong");
  sclk_idle_a: assert property (quiet_s |->
    shift_clock_out == shift_clock_low_in) else $error("sclk idle wrong");
  data_follow_a: assert property (word_req_out |=>
    panel_data_lines_out == $past(pixel_word_in)) else $error("data lost");
  req_busy_a: assert property (word_req_out |-> busy_out)
    else $error("word taken while idle");
  req_live_a: assert property (word_req_out |-> enable_in)
    else $error("word requested while disabled");
  abort_idle_a: assert property ($fell(enable_in) |-> ##[1:2] !busy_out)
    else $error("busy after disable");
endmodule // ppst_chk
bind ppst_timing ppst_chk #(.MAX_BW(MAX_BW)) u_chk (.clk_sys_in, .rst_in,
  .enable_in, .frame_sync_low_in, .line_sync_low_in, .shift_clock_low_in,
  .pixel_word_in, .word_req_out, .panel_data_lines_out, .frame_sync_out,
  .line_sync_out, .shift_clock_out, .busy_out);
`default_nettype wire

//--- tb/ppst_panel_model.sv
// passive panel model timing the sync and shift clock edges
`timescale 1ns/1ps
`default_nettype none
module ppst_panel_model (
  input wire logic       fs_in,
  input wire logic       ls_in,
  input wire logic       sc_in,
  input wire logic [2:0] low_in,
  output var real        t1_out,
  output var real        lw_out,
  output var real        t3_out,
  output var real        shift_period_out,
  output var real        gap_out,
  output var int         fs_n_out,
  output var int         ls_n_out
);
  real t_ls, t_fs, t_sc, t_off;
  int sc_n;
  // panel works on active levels whatever polarity is chosen
  wire logic fs_a = fs_in ^ low_in[2];
  wire logic ls_a = ls_in ^ low_in[1];
  wire logic sc_a = sc_in ^ low_in[0];
  always @(posedge ls_a) begin
    gap_out = $realtime - t_off;
    t_ls = $realtime;
    ls_n_out++;
  end
  always @(negedge ls_a) lw_out = $realtime - t_ls;
  always @(posedge fs_a) begin
    t1_out = $realtime - t_ls;
    t_fs = $realtime;
    sc_n = 0;
    fs_n_out++;
  end
  // active edge is where a panel latches its data
  always @(posedge sc_a) begin
    if (sc_n == 0) t3_out = $realtime - t_fs;
    else shift_period_out = $realtime - t_sc;
    t_sc = $realtime;
    sc_n++;
  end
  always @(negedge sc_a) t_off = $realtime;
endmodule // ppst_panel_model
`default_nettype wire

//--- tb/ppst_timing_tb.sv
// self-checking bench for the passive panel timing generator
`timescale 1ns/1ps
`default_nettype none
module ppst_timing_tb;
  logic clk_sys_in = 1'b0, rst_in = 1'b1, enable_in = 1'b0, src = 1'b0;
  logic [7:0] div = 8'h00, sw = 8'h00, ww = 8'h00, ew = 8'h00, word = 8'h00;
  logic [3:0] bw = 4'h2;
  logic [2:0] pol = 3'h0;
  wire logic req, fs, ls, sc;
  real t1, lw, t3, shift_period, gap;
  int fs_n, ls_n, fail_count = 0, tests_run = 0;
  always #2.5 clk_sys_in = ~clk_sys_in;
  // 40 MHz source, offset so its edges never meet the system clock
  initial #1 forever #12.5 src = ~src;
  always @(posedge clk_sys_in) if (req) word <= word + 8'h01;
  ppst_timing i_dut (.clk_sys_in, .rst_in, .enable_in,
    .display_source_clock_in(src), .pixel_clock_divider_in(div),
    .panel_bus_width_in(bw), .line_start_wait_in(sw),
    .line_sync_width_in(ww), .line_end_wait_in(ew),
    .shifts_per_line_in(10'h002), .lines_per_frame_in(10'h002),
    .frame_sync_low_in(pol[2]), .line_sync_low_in(pol[1]),
    .shift_clock_low_in(pol[0]), .pixel_word_in(word), .word_req_out(req),
    .panel_data_lines_out(), .frame_sync_out(fs), .line_sync_out(ls),
    .shift_clock_out(sc), .busy_out());
  ppst_panel_model i_panel (.fs_in(fs), .ls_in(ls), .sc_in(sc),
    .low_in(pol), .t1_out(t1), .lw_out(lw), .t3_out(t3),
    .shift_period_out(shift_period), .gap_out(gap), .fs_n_out(fs_n),
    .ls_n_out(ls_n));
  task chk(input bit ok);
    tests_run++;
    if (!ok) begin
      fail_count++;
      $display("CHECK FAILED %0t interval off", $time);
    end
  endtask
  function bit near(real a, real e);
    return a > e - 0.1 && a < e + 0.1;
  endfunction
  task conclude;
    $display("checks %0d failures %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one frame start and the following line under one setting
  task run_cfg(input [7:0] d, s, w, e, input [3:0] b, input [2:0] p);
    real tp;
    int f0, k;
    begin
      @(posedge clk_sys_in);
      div <= d;
      sw <= s;
      ww <= w;
      ew <= e;
      bw <= b;
      pol <= p;
      repeat (8) @(posedge clk_sys_in);
      f0 = fs_n;
      enable_in <= 1'b1;
      for (k = 0; k < 9000 && fs_n == f0; k++) @(posedge clk_sys_in);
      chk(k < 9000);
      f0 = ls_n;
      for (k = 0; k < 9000 && ls_n == f0; k++) @(posedge clk_sys_in);
      chk(k < 9000);
      tp = (d + 1) * 25.0;
      chk(near(t1, (s + 2) * tp));
      chk(near(lw, (w + 1) * tp));
      chk(t3 >= 0.0 && t3 <= b * tp);
      chk(near(shift_period, b * tp));
      chk(near(gap, (e + 1) * tp));
      enable_in <= 1'b0;
    end
  endtask
  // shift clock stays at or below 20 MHz, under a fifth of the system clock
  initial begin
    repeat (20) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    run_cfg(8'h00, 8'h00, 8'h00, 8'h00, 4'h2, 3'h0);
    run_cfg(8'h01, 8'h03, 8'h02, 8'h01, 4'h3, 3'h7);
    run_cfg(8'h02, 8'h01, 8'h04, 8'h02, 4'h8, 3'h2);
    run_cfg(8'h00, 8'h02, 8'h01, 8'h03, 4'h5, 3'h5);
    conclude;
  end
  // cut a hang short well past the expected run length
  initial begin
    #100000;
    fail_count++;
    conclude;
  end
endmodule // ppst_timing_tb
`default_nettype wire
